// ===== rtl/fsl_pkg.sv
// Constants, types and register map of the fault status and lock-up block
// How it works
// - Hard-fault status keeps three cause flags, each cleared by writing one.
// - Configurable status word is 32 bits: usage, bus, memmgmt fields joined.
// - New faults add status bits; only a written one clears a bit.
// - Bus and memmgmt fields hold a valid flag set when their address loads.
// - Memmgmt address captures data access violations only.
// - Bus address captures precise data errors only.
// - The two address registers may be separate or one shared register.
// - Trap enables turn divide-by-zero and unaligned accesses into usage faults.
// - Faults or service calls at priority -1/-2 skip normal exception entry.
// - Locked up, one fixed address is fetched and executed repeatedly.
// - Lock-up on precise load/store error with write-back restores the base.
// - Lock-up holds non-zero conditional-block state bits unadvanced.
// - Lock-up entry sets the debug lock-up bit and matching status bits.
// - An external output signals that lock-up has been entered.
// - NMI during hard-fault lock-up is taken; return link is lock address.
// - System reset ends lock-up and resets everything normally.
// - Debug halt during lock-up enters debug with PC at return context.
// - Vector read failure at reset or hard-fault entry locks at -1, all ones.
// - NMI vector read failure locks at -2 fetching all ones.
// - Fetch bus fault at -1/-2 locks; a later good fetch resumes.
// - Imprecise data bus fault at -1/-2 only becomes pending.
// - Precise data bus fault at -1/-2 locks, or only sets status if ignored.
package fsl_pkg;
  localparam int unsigned FSL_PAW = 12;
  // Register byte offsets
  localparam logic [11:0] FSL_OFF_CTRL = 12'h000;
  localparam logic [11:0] FSL_OFF_CONFIGURABLE_FAULT_STATUS = 12'h004;
  localparam logic [11:0] FSL_OFF_HARD_FAULT_STATUS = 12'h008;
  localparam logic [11:0] FSL_OFF_MEMMGMT_FAULT_ADDRESS = 12'h00C;
  localparam logic [11:0] FSL_OFF_BUS_FAULT_ADDRESS = 12'h010;
  localparam logic [11:0] FSL_OFF_LSTAT = 12'h014;
  localparam logic [11:0] FSL_OFF_LADDR = 12'h018;
  // Control bits
  localparam int unsigned FSL_CTRL_W = 3;
  localparam int unsigned FSL_CTRL_IGN = 0;
  localparam int unsigned FSL_CTRL_DIV = 1;
  localparam int unsigned FSL_CTRL_UNAL = 2;
  localparam logic [2:0] FSL_CTRL_RST = 3'h0;
  // Configurable status word: memmgmt [7:0], bus [15:8], usage [31:16]
  localparam int unsigned FSL_CF_IACC = 0;
  localparam int unsigned FSL_CF_DACC = 1;
  localparam int unsigned FSL_CF_MSTK = 4;
  localparam int unsigned FSL_CF_MMVALID = 7;
  localparam int unsigned FSL_CF_IBUS = 8;
  localparam int unsigned FSL_CF_PREC = 9;
  localparam int unsigned FSL_CF_IMPREC = 10;
  localparam int unsigned FSL_CF_STK = 12;
  localparam int unsigned FSL_CF_BFVALID = 15;
  localparam int unsigned FSL_CF_UNDEF = 16;
  localparam int unsigned FSL_CF_INVST = 17;
  localparam int unsigned FSL_CF_INVPC = 18;
  localparam int unsigned FSL_CF_NOCP = 19;
  localparam int unsigned FSL_CF_UNAL = 24;
  localparam int unsigned FSL_CF_DIV0 = 25;
  // Hard-fault status bits
  localparam int unsigned FSL_HF_VTBL = 1;
  localparam int unsigned FSL_HF_FORCED = 30;
  localparam int unsigned FSL_HF_DBG = 31;
  localparam logic [31:0] FSL_LOCK_VEC_ADDR = 32'hFFFFFFFF;
  localparam logic [31:0] FSL_REG_RST = 32'h0;

  typedef enum logic [4:0] {
    FSL_C_NONE = 5'h00, FSL_C_MM_DATA = 5'h01, FSL_C_MM_INSTR = 5'h02,
    FSL_C_MM_STACK = 5'h03, FSL_C_BUS_INSTR = 5'h04,
    FSL_C_BUS_PREC = 5'h05, FSL_C_BUS_IMPREC = 5'h06,
    FSL_C_BUS_STACK = 5'h07, FSL_C_UNDEF = 5'h08, FSL_C_INVSTATE = 5'h09,
    FSL_C_INVPC = 5'h0A, FSL_C_NOCP = 5'h0B, FSL_C_UNALIGNED = 5'h0C,
    FSL_C_DIVZERO = 5'h0D, FSL_C_SVC = 5'h0E, FSL_C_VT_RESET = 5'h0F,
    FSL_C_VT_NMI = 5'h10, FSL_C_VT_HARD = 5'h11
  } fsl_cause_t;

  typedef enum logic [1:0] {
    FSL_PRIO_NORM = 2'h0, FSL_PRIO_M1 = 2'h1, FSL_PRIO_M2 = 2'h2
  } fsl_prio_t;

  typedef enum logic [1:0] {
    FSL_EXC_MEM = 2'h0, FSL_EXC_BUS = 2'h1, FSL_EXC_USAGE = 2'h2,
    FSL_EXC_SVC = 2'h3
  } fsl_exc_kind_t;

  typedef enum logic [1:0] {
    FSL_ST_RUN = 2'b01, FSL_ST_LOCK = 2'b10
  } fsl_state_t;

  typedef struct packed {
    logic valid;
    fsl_cause_t cause;
    fsl_prio_t prio;
    logic [31:0] pc;
    logic [31:0] addr;
    logic base_wb;
    logic it_nonzero;
    logic forced;
  } fsl_fault_ev_t;

  typedef struct packed {
    logic valid;
    logic err;
  } fsl_fetch_rsp_t;

  typedef struct packed {
    logic valid;
    fsl_exc_kind_t kind;
  } fsl_exc_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic prio_m2;
    logic hold_it;
  } fsl_lock_info_t;
endpackage

// ===== rtl/fsl_w1c_bits.sv
// Sticky status bits that hardware sets and software clears by writing one
`timescale 1ns/1ps
`default_nettype none
module fsl_w1c_bits #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] set_bits,
  input wire logic [WIDTH-1:0] clr_bits,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] q_ff;
  logic [WIDTH-1:0] nxt_q;

  // Refuse a width the logic cannot hold
  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("fsl_w1c_bits: WIDTH must be 1 to 32");
  end

  // Set wins over a clear in the same cycle
  assign nxt_q = (q_ff & ~clr_bits) | set_bits;
  assign q = q_ff;

  // Status storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/fsl_fault_unit.sv
// Fault status recording, fault addresses and lock-up control
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fsl_fault_unit #(
  parameter bit SHARED_FAR = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fsl_pkg::FSL_PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fsl_pkg::fsl_fault_ev_t fault_ev,
  input wire logic bkpt_escalated,
  input wire fsl_pkg::fsl_fetch_rsp_t lock_fetch_rsp,
  input wire logic nmi_req,
  input wire logic dbg_halt_req,
  output fsl_pkg::fsl_exc_req_t exc_req,
  output logic bus_fault_pend,
  output logic lockup,
  output logic dbg_lockup_flag,
  output fsl_pkg::fsl_lock_info_t lock_info,
  output logic lock_fetch_req,
  output logic lock_exec,
  output logic restore_base,
  output logic resume,
  output logic nmi_take,
  output logic dbg_enter,
  output logic [31:0] return_pc
);
  import fsl_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // APB decode
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire sel_ctrl = paddr == FSL_OFF_CTRL;
  wire sel_configurable_fault_status = paddr == FSL_OFF_CONFIGURABLE_FAULT_STATUS;
  wire sel_hard_fault_status = paddr == FSL_OFF_HARD_FAULT_STATUS;
  wire sel_memmgmt_fault_address = paddr == FSL_OFF_MEMMGMT_FAULT_ADDRESS;
  wire sel_bus_fault_address = paddr == FSL_OFF_BUS_FAULT_ADDRESS;
  wire sel_lstat = paddr == FSL_OFF_LSTAT;
  wire sel_laddr = paddr == FSL_OFF_LADDR;
  wire mapped = sel_ctrl || sel_configurable_fault_status || sel_hard_fault_status || sel_memmgmt_fault_address || sel_bus_fault_address
    || sel_lstat || sel_laddr;
  wire wr = access && pwrite && mapped;
  wire rd_setup = setup && !pwrite;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // Registers and state
  logic [FSL_CTRL_W-1:0] ctrl_ff;
  logic [31:0] mm_far_ff;
  logic [31:0] bus_far_ff;
  logic [31:0] prdata_ff;
  fsl_state_t state_ff;
  fsl_state_t nxt_state;
  logic [31:0] lock_addr_ff;
  logic [31:0] nxt_lock_addr;
  logic lock_m2_ff;
  logic lock_ibus_ff;
  logic hold_it_ff;
  logic restore_ff;
  logic exec_ff;
  logic resume_ff;
  logic nmi_take_ff;
  logic dbg_enter_ff;
  logic [31:0] ret_pc_ff;
  logic bus_pend_ff;
  fsl_exc_req_t exc_ff;
  fsl_exc_req_t nxt_exc;
  logic [31:0] configurable_fault_status_q;
  logic [2:0] hard_fault_status_q;

  // Event classification
  wire ev = fault_ev.valid;
  wire fsl_cause_t cause = fault_ev.cause;
  wire hi = fault_ev.prio != FSL_PRIO_NORM;
  wire is_vt = cause inside {FSL_C_VT_RESET, FSL_C_VT_NMI, FSL_C_VT_HARD};
  wire is_mm = cause inside {FSL_C_MM_DATA, FSL_C_MM_INSTR, FSL_C_MM_STACK};
  wire is_bus = cause inside {FSL_C_BUS_INSTR, FSL_C_BUS_PREC,
    FSL_C_BUS_IMPREC, FSL_C_BUS_STACK};
  wire div_en = ctrl_ff[FSL_CTRL_DIV];
  wire unal_en = ctrl_ff[FSL_CTRL_UNAL];
  wire ign_en = ctrl_ff[FSL_CTRL_IGN];
  wire trap_ok = (cause == FSL_C_DIVZERO) ? div_en :
    (cause == FSL_C_UNALIGNED) ? unal_en : 1'b1;
  wire live = ev && trap_ok && cause != FSL_C_NONE;
  wire prec_ign = cause == FSL_C_BUS_PREC && hi && ign_en;
  wire imp_pend = live && cause == FSL_C_BUS_IMPREC && hi;
  wire running = state_ff == FSL_ST_RUN;
  // high priority diverts away from normal entry
  wire lock_go = live && running && (is_vt || (hi && !prec_ign &&
    cause != FSL_C_BUS_IMPREC));
  wire normal_go = live && !hi && !is_vt;
  wire mm_load = live && cause == FSL_C_MM_DATA;
  wire bus_load = live && cause == FSL_C_BUS_PREC;

  // Status bit for each cause
  function automatic logic [31:0] cause_mask(input fsl_cause_t c);
    logic [31:0] m;
    m = 32'h0;
    case (c)
      FSL_C_MM_DATA: m = 32'h1 << FSL_CF_DACC;
      FSL_C_MM_INSTR: m = 32'h1 << FSL_CF_IACC;
      FSL_C_MM_STACK: m = 32'h1 << FSL_CF_MSTK;
      FSL_C_BUS_INSTR: m = 32'h1 << FSL_CF_IBUS;
      FSL_C_BUS_PREC: m = 32'h1 << FSL_CF_PREC;
      FSL_C_BUS_IMPREC: m = 32'h1 << FSL_CF_IMPREC;
      FSL_C_BUS_STACK: m = 32'h1 << FSL_CF_STK;
      FSL_C_UNDEF: m = 32'h1 << FSL_CF_UNDEF;
      FSL_C_SVC: m = 32'h1 << FSL_CF_UNDEF;
      FSL_C_INVSTATE: m = 32'h1 << FSL_CF_INVST;
      FSL_C_INVPC: m = 32'h1 << FSL_CF_INVPC;
      FSL_C_NOCP: m = 32'h1 << FSL_CF_NOCP;
      FSL_C_UNALIGNED: m = 32'h1 << FSL_CF_UNAL;
      FSL_C_DIVZERO: m = 32'h1 << FSL_CF_DIV0;
      default: m = 32'h0;
    endcase
    return m;
  endfunction

  // valid flags ride with address loads
  wire [31:0] valid_set = (mm_load ? (32'h1 << FSL_CF_MMVALID) : 32'h0)
    | (bus_load ? (32'h1 << FSL_CF_BFVALID) : 32'h0);
  // status set for every live fault, locking or not
  wire [31:0] configurable_fault_status_set = live ? (cause_mask(cause) | valid_set) : 32'h0;
  wire [31:0] configurable_fault_status_clr = (wr && sel_configurable_fault_status) ? pwdata : 32'h0;
  wire [2:0] hard_fault_status_set = {bkpt_escalated, live && fault_ev.forced,
    live && is_vt};
  wire [2:0] hard_fault_status_clr = (wr && sel_hard_fault_status) ?
    {pwdata[FSL_HF_DBG], pwdata[FSL_HF_FORCED], pwdata[FSL_HF_VTBL]} : 3'h0;

  fsl_w1c_bits #(.WIDTH(32)) u_configurable_fault_status (
    .pclk(pclk),
    .presetn(presetn),
    .set_bits(configurable_fault_status_set),
    .clr_bits(configurable_fault_status_clr),
    .q(configurable_fault_status_q)
  );

  fsl_w1c_bits #(.WIDTH(3)) u_hard_fault_status (
    .pclk(pclk),
    .presetn(presetn),
    .set_bits(hard_fault_status_set),
    .clr_bits(hard_fault_status_clr),
    .q(hard_fault_status_q)
  );

  // Read mux
  wire [31:0] mm_far_rd = mm_far_ff;
  wire [31:0] bus_far_rd = SHARED_FAR ? mm_far_ff : bus_far_ff;
  wire [31:0] hard_fault_status_rd = ({31'h0, hard_fault_status_q[2]} << FSL_HF_DBG)
    | ({31'h0, hard_fault_status_q[1]} << FSL_HF_FORCED)
    | ({31'h0, hard_fault_status_q[0]} << FSL_HF_VTBL);
  wire [31:0] rd_data = sel_ctrl ? {29'h0, ctrl_ff} :
    sel_configurable_fault_status ? configurable_fault_status_q :
    sel_hard_fault_status ? hard_fault_status_rd :
    sel_memmgmt_fault_address ? mm_far_rd :
    sel_bus_fault_address ? bus_far_rd :
    sel_lstat ? {29'h0, hold_it_ff, lock_m2_ff, lockup} :
    sel_laddr ? lock_addr_ff : 32'h0;

  // Control register and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= FSL_CTRL_RST;
      prdata_ff <= FSL_REG_RST;
    end else begin
      if (wr && sel_ctrl) begin
        ctrl_ff <= pwdata[FSL_CTRL_W-1:0];
      end
      if (rd_setup) begin
        prdata_ff <= rd_data;
      end
    end
  end

  wire [31:0] nxt_mm_far = mm_load ? fault_ev.addr :
    (SHARED_FAR && bus_load) ? fault_ev.addr :
    (wr && (sel_memmgmt_fault_address || (SHARED_FAR && sel_bus_fault_address))) ? pwdata : mm_far_ff;
  wire [31:0] nxt_bus_far = SHARED_FAR ? FSL_REG_RST :
    bus_load ? fault_ev.addr : (wr && sel_bus_fault_address) ? pwdata : bus_far_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mm_far_ff <= FSL_REG_RST;
      bus_far_ff <= FSL_REG_RST;
    end else begin
      mm_far_ff <= nxt_mm_far;
      bus_far_ff <= nxt_bus_far;
    end
  end

  // Normal exception request and its kind
  always_comb begin
    nxt_exc.valid = normal_go;
    nxt_exc.kind = is_mm ? FSL_EXC_MEM : is_bus ? FSL_EXC_BUS :
      (cause == FSL_C_SVC) ? FSL_EXC_SVC : FSL_EXC_USAGE;
  end

  // Lock-up exits and events
  wire fetch_ok = lock_fetch_rsp.valid && !lock_fetch_rsp.err;
  wire halt_exit = !running && dbg_halt_req;
  wire nmi_exit = !running && !lock_m2_ff && nmi_req && !dbg_halt_req;
  wire auto_exit = !running && lock_ibus_ff && fetch_ok && !dbg_halt_req
    && !nmi_exit;
  // vector failures lock at all ones
  wire [31:0] go_addr = is_vt ? FSL_LOCK_VEC_ADDR : fault_ev.pc;
  wire go_m2 = (cause == FSL_C_VT_NMI) ||
    (!is_vt && fault_ev.prio == FSL_PRIO_M2);

  // Lock-up state machine
  always_comb begin
    nxt_state = state_ff;
    nxt_lock_addr = lock_addr_ff;
    case (state_ff)
      FSL_ST_RUN: begin
        if (lock_go) begin
          nxt_state = FSL_ST_LOCK;
          nxt_lock_addr = go_addr;
        end
      end
      FSL_ST_LOCK: begin
        if (halt_exit || nmi_exit || auto_exit) begin
          nxt_state = FSL_ST_RUN;
        end
      end
      default: begin
        nxt_state = FSL_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= FSL_ST_RUN;
      lock_addr_ff <= FSL_REG_RST;
    end else begin
      state_ff <= nxt_state;
      lock_addr_ff <= nxt_lock_addr;
    end
  end

  // Captured lock-up context
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_m2_ff <= 1'b0;
      lock_ibus_ff <= 1'b0;
      hold_it_ff <= 1'b0;
    end else if (lock_go) begin
      lock_m2_ff <= go_m2;
      lock_ibus_ff <= cause == FSL_C_BUS_INSTR;
      hold_it_ff <= fault_ev.it_nonzero;
    end else if (nxt_state == FSL_ST_RUN) begin
      lock_m2_ff <= 1'b0;
      lock_ibus_ff <= 1'b0;
      hold_it_ff <= 1'b0;
    end
  end

  // One-cycle strobes and return context
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_ff <= 1'b0;
      exec_ff <= 1'b0;
      resume_ff <= 1'b0;
      nmi_take_ff <= 1'b0;
      dbg_enter_ff <= 1'b0;
      ret_pc_ff <= FSL_REG_RST;
      bus_pend_ff <= 1'b0;
      exc_ff <= '0;
    end else begin
      restore_ff <= lock_go && fault_ev.base_wb &&
        (cause == FSL_C_BUS_PREC || cause == FSL_C_MM_DATA);
      // a good lock fetch is executed again
      exec_ff <= !running && fetch_ok && !lock_ibus_ff && !halt_exit
        && !nmi_exit;
      resume_ff <= auto_exit;
      nmi_take_ff <= nmi_exit;
      dbg_enter_ff <= halt_exit;
      if (halt_exit || nmi_exit) begin
        ret_pc_ff <= lock_addr_ff;
      end
      bus_pend_ff <= imp_pend;
      exc_ff <= nxt_exc;
    end
  end

  // Outputs
  // lock-up level out and debug flag
  assign lockup = state_ff == FSL_ST_LOCK;
  assign dbg_lockup_flag = lockup;
  assign lock_fetch_req = lockup;
  assign lock_info = '{addr: lock_addr_ff, prio_m2: lock_m2_ff,
    hold_it: hold_it_ff};
  assign lock_exec = exec_ff;
  assign restore_base = restore_ff;
  assign resume = resume_ff;
  assign nmi_take = nmi_take_ff;
  assign dbg_enter = dbg_enter_ff;
  assign return_pc = ret_pc_ff;
  assign bus_fault_pend = bus_pend_ff;
  assign exc_req = exc_ff;
  assign prdata = prdata_ff;

  // Checks
  chk_hard_fault_status_sticky: assert property (
    !(wr && sel_hard_fault_status) |=> ((hard_fault_status_q & $past(hard_fault_status_q)) == $past(hard_fault_status_q)))
    else $error("hard fault flag fell without a write");
  chk_configurable_fault_status_additive: assert property (
    live && !(wr && sel_configurable_fault_status) |=> (configurable_fault_status_q & $past(configurable_fault_status_set))
      == $past(configurable_fault_status_set))
    else $error("fault status bit not set");
  chk_mm_valid: assert property (
    mm_load && !SHARED_FAR |=> configurable_fault_status_q[FSL_CF_MMVALID]
      && mm_far_ff == $past(fault_ev.addr))
    else $error("memmgmt address or valid flag missing");
  chk_bus_fault_address_keep: assert property (
    ev && cause != FSL_C_BUS_PREC && !wr |=> $stable(bus_far_rd)
      || SHARED_FAR)
    else $error("bus fault address changed");
  chk_div_gate: assert property (
    ev && cause == FSL_C_DIVZERO && !div_en |=> !exc_req.valid
      && !$rose(lockup))
    else $error("divide by zero trapped while disabled");
  chk_vt_lock: assert property (
    ev && is_vt && running |=> lockup
      && lock_info.addr == FSL_LOCK_VEC_ADDR ##1 lockup || !$past(lockup))
    else $error("vector failure did not lock at all ones");
  chk_imp_pend: assert property (
    imp_pend && running |=> bus_fault_pend && !lockup && !exc_req.valid)
    else $error("imprecise error at high priority not pending");
  chk_prec_ign: assert property (
    live && prec_ign && running |=> !lockup && configurable_fault_status_q[FSL_CF_PREC])
    else $error("ignored precise error locked up");
  chk_nmi_link: assert property (
    nmi_exit |=> nmi_take && !lockup && return_pc == $past(lock_addr_ff))
    else $error("nmi did not leave lock-up with lock address");
  chk_halt_pc: assert property (
    halt_exit |=> dbg_enter && !lockup && return_pc == $past(lock_addr_ff))
    else $error("halt did not enter debug at return context");
endmodule
`default_nettype wire

// ===== verification/fsl_far_side.sv
// Far-side model: memory answering the repeated lock-address fetch
`timescale 1ns/1ps
`default_nettype none
module fsl_far_side
  import fsl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lock_fetch_req,
  input wire logic fetch_bad,
  input wire logic [3:0] gap,
  output fsl_pkg::fsl_fetch_rsp_t lock_fetch_rsp
);
  logic [3:0] cnt_ff;

  // Fetch answers that error while the fault lasts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 4'h0;
      lock_fetch_rsp <= '0;
    end else if (lock_fetch_req && cnt_ff >= gap) begin
      cnt_ff <= 4'h0;
      lock_fetch_rsp <= '{valid: 1'b1, err: fetch_bad};
    end else begin
      cnt_ff <= lock_fetch_req ? cnt_ff + 4'h1 : 4'h0;
      // Idle error line shows the inverse of its last value
      lock_fetch_rsp <= '{valid: 1'b0, err: ~lock_fetch_rsp.err};
    end
  end
endmodule
`default_nettype wire

// ===== verification/test_fault_status_and_lockup.sv
// Self-checking bench for the fault status and lock-up block
`timescale 1ns/1ps
`default_nettype none
module test_fault_status_and_lockup;
  import fsl_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fsl_fault_ev_t fault_ev = '0;
  logic bkpt_escalated = 1'b0;
  fsl_fetch_rsp_t lock_fetch_rsp;
  logic nmi_req = 1'b0;
  logic dbg_halt_req = 1'b0;
  fsl_exc_req_t exc_req;
  logic bus_fault_pend, lockup, dbg_lockup_flag, lock_fetch_req, lock_exec;
  fsl_lock_info_t lock_info;
  logic restore_base, resume, nmi_take, dbg_enter;
  logic [31:0] return_pc;
  logic fetch_bad = 1'b0;
  logic [31:0] rd_q, rpc_s;
  logic err_q, lk_s, pend_s, rb_s, nmi_s, dbg_s;
  logic [2:0] exc_s;
  int n_errors = 0;
  int n_checks = 0;
  int i;

  fsl_fault_unit u_fsl_fault_unit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_ev(fault_ev),
    .bkpt_escalated(bkpt_escalated), .lock_fetch_rsp(lock_fetch_rsp),
    .nmi_req(nmi_req), .dbg_halt_req(dbg_halt_req), .exc_req(exc_req),
    .bus_fault_pend(bus_fault_pend), .lockup(lockup),
    .dbg_lockup_flag(dbg_lockup_flag), .lock_info(lock_info),
    .lock_fetch_req(lock_fetch_req), .lock_exec(lock_exec),
    .restore_base(restore_base), .resume(resume), .nmi_take(nmi_take),
    .dbg_enter(dbg_enter), .return_pc(return_pc)
  );

  fsl_far_side u_fsl_far_side (
    .pclk(pclk), .presetn(presetn), .lock_fetch_req(lock_fetch_req),
    .fetch_bad(fetch_bad), .gap(4'h3), .lock_fetch_rsp(lock_fetch_rsp)
  );

  // Clock at 100 MHz
  always #5 pclk = ~pclk;

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Capture the pulses shown after a taking edge
  task automatic snap;
    #1;
    lk_s = lockup;
    pend_s = bus_fault_pend;
    rb_s = restore_base;
    exc_s = exc_req;
    nmi_s = nmi_take;
    dbg_s = dbg_enter;
    rpc_s = return_pc;
    @(posedge pclk);
  endtask

  // One fault event; f is base write-back, conditional state, forced
  task automatic ev(input fsl_cause_t c, input fsl_prio_t p,
                    input logic [31:0] pc, input logic [31:0] a,
                    input logic [2:0] f);
    fault_ev <= '{valid: 1'b1, cause: c, prio: p, pc: pc, addr: a,
                  base_wb: f[2], it_nonzero: f[1], forced: f[0]};
    @(posedge pclk);
    fault_ev.valid <= 1'b0;
    snap();
  endtask

  // Pulse a lock-up exit request: halt when h is set, else NMI
  task automatic leave(input logic h);
    if (h) dbg_halt_req <= 1'b1;
    else nmi_req <= 1'b1;
    @(posedge pclk);
    nmi_req <= 1'b0;
    dbg_halt_req <= 1'b0;
    snap();
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped address
    apb(1'b0, FSL_OFF_CONFIGURABLE_FAULT_STATUS, 32'h0); chk("configurable_fault_status", 32'h0, rd_q);
    apb(1'b0, 12'h020, 32'h0); chk("slverr", 32'h1, 32'(err_q));
    chk("pready", 32'h1, 32'(pready));
    // Address capture only for the documented causes
    ev(FSL_C_BUS_PREC, FSL_PRIO_NORM, 32'h100, 32'hA0, 3'h0);
    chk("exc_bus", 32'h5, 32'(exc_s));
    ev(FSL_C_BUS_IMPREC, FSL_PRIO_NORM, 32'h104, 32'hB0, 3'h0);
    ev(FSL_C_BUS_INSTR, FSL_PRIO_NORM, 32'h108, 32'hB4, 3'h0);
    ev(FSL_C_BUS_STACK, FSL_PRIO_NORM, 32'h10C, 32'hB8, 3'h0);
    ev(FSL_C_MM_INSTR, FSL_PRIO_NORM, 32'h110, 32'hC0, 3'h0);
    ev(FSL_C_MM_STACK, FSL_PRIO_NORM, 32'h114, 32'hC4, 3'h0);
    apb(1'b0, FSL_OFF_MEMMGMT_FAULT_ADDRESS, 32'h0); chk("mmfar0", 32'h0, rd_q);
    ev(FSL_C_MM_DATA, FSL_PRIO_NORM, 32'h118, 32'hD0, 3'h0);
    ev(FSL_C_DIVZERO, FSL_PRIO_NORM, 32'h11C, 32'h0, 3'h0);
    chk("exc_off", 32'h0, 32'(exc_s[2]));
    ev(FSL_C_UNALIGNED, FSL_PRIO_NORM, 32'h120, 32'hD2, 3'h0);
    apb(1'b0, FSL_OFF_MEMMGMT_FAULT_ADDRESS, 32'h0); chk("memmgmt_fault_address", 32'hD0, rd_q);
    apb(1'b0, FSL_OFF_BUS_FAULT_ADDRESS, 32'h0); chk("bus_fault_address", 32'hA0, rd_q);
    apb(1'b0, FSL_OFF_CONFIGURABLE_FAULT_STATUS, 32'h0); chk("configurable_fault_status", 32'h9793, rd_q);
    // Clearing two bits leaves the rest
    apb(1'b1, FSL_OFF_CONFIGURABLE_FAULT_STATUS, 32'h0202);
    apb(1'b0, FSL_OFF_CONFIGURABLE_FAULT_STATUS, 32'h0); chk("configurable_fault_status_w1c", 32'h9591, rd_q);
    // Traps enabled
    apb(1'b1, FSL_OFF_CTRL, 32'h6);
    ev(FSL_C_DIVZERO, FSL_PRIO_NORM, 32'h124, 32'h0, 3'h0);
    chk("exc_use", 32'h6, 32'(exc_s));
    ev(FSL_C_UNALIGNED, FSL_PRIO_NORM, 32'h128, 32'hD2, 3'h0);
    apb(1'b0, FSL_OFF_CONFIGURABLE_FAULT_STATUS, 32'h0); chk("configurable_fault_status_trap", 32'h03009591, rd_q);
    // Imprecise at high priority only pends
    ev(FSL_C_BUS_IMPREC, FSL_PRIO_M1, 32'h200, 32'h0, 3'h0);
    chk("pend", 32'h1, 32'(pend_s));
    chk("no_lock", 32'h0, 32'(lk_s));
    // Ignored precise error does not lock and still records its bus fault address
    apb(1'b1, FSL_OFF_CTRL, 32'h1);
    ev(FSL_C_BUS_PREC, FSL_PRIO_M1, 32'h204, 32'hE0, 3'h0);
    chk("ign_lock", 32'h0, 32'(lk_s));
    apb(1'b0, FSL_OFF_BUS_FAULT_ADDRESS, 32'h0); chk("ign_bus_fault_address", 32'hE0, rd_q);
    // Precise error locks, base restored, conditional state held
    apb(1'b1, FSL_OFF_CTRL, 32'h0);
    ev(FSL_C_BUS_PREC, FSL_PRIO_M1, 32'h300, 32'hF0, 3'h6);
    chk("lock", 32'h1, 32'(lk_s));
    chk("restore", 32'h1, 32'(rb_s));
    chk("dbg_flag", 32'h1, 32'(dbg_lockup_flag));
    chk("fetch_req", 32'h1, 32'(lock_fetch_req));
    chk("laddr", 32'h300, lock_info.addr);
    chk("hold_it", 32'h1, 32'(lock_info.hold_it));
    // A good lock fetch is handed on for execution
    for (i = 0; i < 8 && lock_exec !== 1'b1; i++) @(posedge pclk);
    chk("exec", 32'h1, 32'(lock_exec));
    apb(1'b0, FSL_OFF_LSTAT, 32'h0); chk("lstat", 32'h5, rd_q);
    leave(1'b0);
    chk("nmi_take", 32'h1, 32'(nmi_s));
    chk("nmi_pc", 32'h300, rpc_s);
    chk("nmi_exit", 32'h0, 32'(lk_s));
    // NMI vector failure locks at -2 and ignores NMI
    ev(FSL_C_VT_NMI, FSL_PRIO_M2, 32'h0, 32'h0, 3'h0);
    chk("vn_addr", FSL_LOCK_VEC_ADDR, lock_info.addr);
    chk("vn_m2", 32'h1, 32'(lock_info.prio_m2));
    leave(1'b0);
    chk("nmi_ign", 32'h1, 32'(lk_s));
    leave(1'b1);
    chk("dbg_ent", 32'h1, 32'(dbg_s));
    chk("dbg_pc", FSL_LOCK_VEC_ADDR, rpc_s);
    // Reset vector failure, then system reset mid-lock
    ev(FSL_C_VT_RESET, FSL_PRIO_M1, 32'h0, 32'h0, 3'h0);
    chk("vr_addr", FSL_LOCK_VEC_ADDR, lock_info.addr);
    chk("vr_m1", 32'h0, 32'(lock_info.prio_m2));
    apb(1'b0, FSL_OFF_HARD_FAULT_STATUS, 32'h0); chk("hf_vt", 32'h2, rd_q);
    presetn <= 1'b0;
    @(posedge pclk);
    #1 chk("rst_lock", 32'h0, 32'(lockup));
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, FSL_OFF_HARD_FAULT_STATUS, 32'h0); chk("rst_hf", 32'h0, rd_q);
    // Service call at -1 locks
    ev(FSL_C_SVC, FSL_PRIO_M1, 32'h400, 32'h0, 3'h0);
    chk("svc_lock", 32'h1, 32'(lk_s));
    leave(1'b0);
    // Fetch fault at -2 resumes once fetches succeed
    fetch_bad <= 1'b1;
    ev(FSL_C_BUS_INSTR, FSL_PRIO_M2, 32'h500, 32'h0, 3'h0);
    repeat (20) @(posedge pclk);
    chk("bad_fetch", 32'h1, 32'(lockup));
    fetch_bad <= 1'b0;
    for (i = 0; i < 60 && resume !== 1'b1; i++) @(posedge pclk);
    chk("resume", 32'h1, 32'(resume));
    chk("res_exit", 32'h0, 32'(lockup));
    @(posedge pclk);
    // Hard-fault flags and their clearing
    bkpt_escalated <= 1'b1;
    @(posedge pclk);
    bkpt_escalated <= 1'b0;
    ev(FSL_C_UNDEF, FSL_PRIO_NORM, 32'h600, 32'h0, 3'h1);
    apb(1'b0, FSL_OFF_HARD_FAULT_STATUS, 32'h0); chk("hf", 32'hC0000000, rd_q);
    apb(1'b1, FSL_OFF_HARD_FAULT_STATUS, 32'h80000000);
    apb(1'b0, FSL_OFF_HARD_FAULT_STATUS, 32'h0); chk("hf_w1c", 32'h40000000, rd_q);
    final_report();
  end
endmodule
`default_nettype wire
